/* pfa_cfg.svh */
// Constants for the program flow and addressing block
`ifndef PFA_CFG_SVH
`define PFA_CFG_SVH

// Program counter and stack geometry
`define PFA_PC_W        11
`define PFA_STK_W       12
`define PFA_STK_DEPTH   4
`define PFA_PC_RST      11'h7ff
`define PFA_PC_ONE      11'h001
`define PFA_IRQ_VEC     11'h004
`define PFA_STK_RST     12'h000

// Data addressing
`define PFA_BANK_RST    3'h0
`define PFA_PAGE_RST    3'h0
`define PFA_FSR_RST     8'h00
`define PFA_IND_FILE    5'h00
`define PFA_PCL_FILE    5'h02
`define PFA_FSR_FILE    5'h04
`define PFA_ZERO_BYTE   8'h00

// APB register byte offsets
`define PFA_ADR_PC      12'h000
`define PFA_ADR_CTRL    12'h004
`define PFA_ADR_FSR     12'h008
`define PFA_ADR_TOP     12'h00c

// Control register fields
`define PFA_CTRL_BANK   2:0
`define PFA_CTRL_PAGE   6:4

`endif

/* pfa_pkg.sv */
// Types for the program flow and addressing block
package pfa_pkg;

  // Commands retired by the instruction decoder
  typedef enum logic [3:0] {
    PFA_OP_NONE   = 4'h0,
    PFA_OP_JUMP   = 4'h1,
    PFA_OP_CALL   = 4'h2,
    PFA_OP_RET    = 4'h3,
    PFA_OP_RETLIT = 4'h4,
    PFA_OP_RETINT = 4'h5,
    PFA_OP_IRQ    = 4'h6,
    PFA_OP_PCLWR  = 4'h7,
    PFA_OP_BANK   = 4'h8,
    PFA_OP_PAGE   = 4'h9
  } pfa_op_t;

  // All state of the block
  typedef struct packed {
    logic [10:0]      pc;
    logic [2:0]       page;
    logic [2:0]       bank;
    logic [7:0]       file_pointer;
    logic [3:0][11:0] stk;
    logic             wload;
    logic [7:0]       wval;
    logic [7:0]       maddr;
    logic             mre;
    logic             mwe;
    logic [7:0]       mwdata;
    logic             rpend;
    logic             rloc;
    logic [7:0]       rlocval;
    logic             rvalid;
    logic [7:0]       rdata;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } pfa_state_t;

endpackage

/* pfa_core.sv */
// Program counter, return stack and data addressing with APB view
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "pfa_cfg.svh"

module pfa_core
  import pfa_pkg::*;
(
  input  wire logic        pclk,            // Instruction cycle clock
  input  wire logic        presetn,         // Async reset, active low
  input  wire logic        step,            // Instruction retires
  input  pfa_op_t          op,              // Retired command
  input  wire logic [8:0]  field,           // Address or literal field
  input  wire logic [7:0]  result,          // Result for low byte/page
  input  wire logic        acc_req,         // Data access request
  input  wire logic        acc_we,          // Access is a write
  input  wire logic [4:0]  acc_file,        // Opcode file field
  input  wire logic [7:0]  acc_wdata,       // Write data
  input  wire logic [7:0]  dmem_rdata,      // Memory read data
  output logic      [10:0] program_counter, // Current counter
  output logic             wreg_load,       // Load working register
  output logic      [7:0]  wreg_value,      // Literal for it
  output logic      [7:0]  dmem_addr,       // Memory address
  output logic             dmem_re,         // Memory read strobe
  output logic             dmem_we,         // Memory write strobe
  output logic      [7:0]  dmem_wdata,      // Memory write data
  output logic             acc_rvalid,      // Read data valid
  output logic      [7:0]  acc_rdata,       // Read data
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB direction
  input  wire logic [11:0] paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr          // APB error
);

  //--------------------------------------------------------------
  // State
  //--------------------------------------------------------------
  localparam pfa_state_t RST_S = '{
    pc: `PFA_PC_RST, page: `PFA_PAGE_RST, bank: `PFA_BANK_RST,
    file_pointer: `PFA_FSR_RST, stk: {`PFA_STK_DEPTH{`PFA_STK_RST}},
    wload: 1'b0, wval: `PFA_ZERO_BYTE, maddr: `PFA_ZERO_BYTE,
    mre: 1'b0, mwe: 1'b0, mwdata: `PFA_ZERO_BYTE, rpend: 1'b0,
    rloc: 1'b0, rlocval: `PFA_ZERO_BYTE, rvalid: 1'b0,
    rdata: `PFA_ZERO_BYTE, pready: 1'b0, pslverr: 1'b0,
    prdata: 32'h0000_0000};

  pfa_state_t s;
  pfa_state_t next_s;
  logic [11:0] ret_addr;
  logic        apb_acc;
  logic        apb_wr;
  logic        mapped;
  logic [31:0] apb_rd;
  logic [7:0]  ind_addr;
  logic        ind_hit;

  //--------------------------------------------------------------
  // Helper terms
  //--------------------------------------------------------------
  // Return address is current counter plus one
  assign ret_addr = {1'b0, s.pc + `PFA_PC_ONE};
  // Indirect port redirects through the pointer
  assign ind_hit  = (acc_file == `PFA_IND_FILE);
  assign ind_addr = s.file_pointer;
  // APB access phase and register decode
  assign apb_acc  = psel && penable && !s.pready;
  assign apb_wr   = psel && penable && s.pready && pwrite;

  // Read mux and map check
  always_comb begin
    mapped = 1'b1;
    apb_rd = 32'h0000_0000;
    unique case (paddr)
      `PFA_ADR_PC:   apb_rd[10:0] = s.pc;
      `PFA_ADR_CTRL: begin
        apb_rd[`PFA_CTRL_PAGE] = s.page;
        apb_rd[`PFA_CTRL_BANK] = s.bank;
      end
      `PFA_ADR_FSR:  apb_rd[7:0]  = s.file_pointer;
      `PFA_ADR_TOP:  apb_rd[11:0] = s.stk[0];
      default:       mapped = 1'b0;
    endcase
  end

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.wload = 1'b0;
    next_s.mre   = 1'b0;
    next_s.mwe   = 1'b0;
    next_s.rvalid = 1'b0;
    next_s.rpend = 1'b0;

    // Program counter and stack on each retired instruction
    if (step) begin
      unique case (op)
        PFA_OP_NONE: begin
          next_s.pc = s.pc + `PFA_PC_ONE;
        end
        PFA_OP_JUMP: begin
          next_s.pc = {s.page[1:0], field};
        end
        PFA_OP_CALL, PFA_OP_IRQ: begin
          // Shift deeper, deepest falls off silently
          next_s.stk[3] = s.stk[2];
          next_s.stk[2] = s.stk[1];
          next_s.stk[1] = s.stk[0];
          next_s.stk[0] = ret_addr;
          if (op == PFA_OP_CALL) begin
            next_s.pc = {s.page[1:0], 1'b0, field[7:0]};
          end else begin
            next_s.pc = `PFA_IRQ_VEC;
          end
        end
        PFA_OP_RET, PFA_OP_RETLIT, PFA_OP_RETINT: begin
          // Pop level one, level four copied up
          next_s.pc     = s.stk[0][10:0];
          next_s.stk[0] = s.stk[1];
          next_s.stk[1] = s.stk[2];
          next_s.stk[2] = s.stk[3];
          if (op == PFA_OP_RETLIT) begin
            next_s.wload = 1'b1;
            next_s.wval  = field[7:0];
          end
        end
        PFA_OP_PCLWR: begin
          next_s.pc = {s.page[1:0], 1'b0, result};
        end
        PFA_OP_BANK: begin
          next_s.bank = field[2:0];
          next_s.pc   = s.pc + `PFA_PC_ONE;
        end
        PFA_OP_PAGE: begin
          next_s.page = result[7:5];
          next_s.pc   = s.pc + `PFA_PC_ONE;
        end
        default: begin
          next_s.pc = s.pc + `PFA_PC_ONE;
        end
      endcase
    end

    // Data access: direct, indirect, or local alias
    if (acc_req) begin
      next_s.rloc    = 1'b0;
      next_s.rlocval = `PFA_ZERO_BYTE;
      next_s.mwdata  = acc_wdata;
      if (ind_hit) begin
        next_s.maddr = ind_addr;
        if (ind_addr == `PFA_ZERO_BYTE) begin
          next_s.rloc = 1'b1;
        end else begin
          next_s.mre = !acc_we;
          next_s.mwe = acc_we;
        end
      end else begin
        next_s.maddr = {s.bank, acc_file};
        if (acc_file == `PFA_PCL_FILE) begin
          next_s.rloc    = 1'b1;
          next_s.rlocval = s.pc[7:0];
        end else if (acc_file == `PFA_FSR_FILE) begin
          next_s.rloc    = 1'b1;
          next_s.rlocval = s.file_pointer;
          if (acc_we) begin
            next_s.file_pointer = acc_wdata;
          end
        end else begin
          next_s.mre = !acc_we;
          next_s.mwe = acc_we;
        end
      end
      next_s.rpend = !acc_we;
    end

    // Read data returned one cycle after the memory strobe
    if (s.rpend) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = s.rloc ? s.rlocval : dmem_rdata;
    end

    // APB slave: one wait state, then answer
    next_s.pready = apb_acc;
    if (apb_acc) begin
      next_s.prdata  = pwrite ? 32'h0000_0000 : apb_rd;
      next_s.pslverr = !mapped;
    end else if (!psel) begin
      next_s.pslverr = 1'b0;
    end
    if (apb_wr && mapped) begin
      if (paddr == `PFA_ADR_CTRL && !(step && op == PFA_OP_PAGE)) begin
        next_s.page = pwdata[`PFA_CTRL_PAGE];
      end
      if (paddr == `PFA_ADR_CTRL && !(step && op == PFA_OP_BANK)) begin
        next_s.bank = pwdata[`PFA_CTRL_BANK];
      end
      if (paddr == `PFA_ADR_FSR && !(acc_req && acc_we &&
          acc_file == `PFA_FSR_FILE && !ind_hit)) begin
        next_s.file_pointer = pwdata[7:0];
      end
    end
  end

  //--------------------------------------------------------------
  // State register
  //--------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  assign program_counter = s.pc;
  assign wreg_load       = s.wload;
  assign wreg_value      = s.wval;
  assign dmem_addr       = s.maddr;
  assign dmem_re         = s.mre;
  assign dmem_we         = s.mwe;
  assign dmem_wdata      = s.mwdata;
  assign acc_rvalid      = s.rvalid;
  assign acc_rdata       = s.rdata;
  assign prdata          = s.prdata;
  assign pready          = s.pready;
  assign pslverr         = s.pslverr;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence push_seq;
    step && (op == PFA_OP_CALL || op == PFA_OP_IRQ);
  endsequence

  sequence pop_seq;
    step && (op == PFA_OP_RET || op == PFA_OP_RETLIT ||
             op == PFA_OP_RETINT);
  endsequence

  pc_advance_a: assert property (step && op == PFA_OP_NONE |=>
    s.pc == $past(s.pc) + `PFA_PC_ONE)
    else $error("counter did not advance");

  jump_target_a: assert property (step && op == PFA_OP_JUMP |=>
    s.pc == {$past(s.page[1:0]), $past(field)})
    else $error("jump target wrong");

  bit8_clear_a: assert property (step &&
    (op == PFA_OP_CALL || op == PFA_OP_PCLWR) |=> !s.pc[8])
    else $error("bit 8 not cleared");

  stack_push_a: assert property (push_seq |=>
    s.stk[0] == {1'b0, $past(s.pc) + `PFA_PC_ONE} &&
    s.stk[3] == $past(s.stk[2]))
    else $error("push wrong");

  stack_pop_a: assert property (pop_seq |=>
    s.pc == $past(s.stk[0][10:0]) && s.stk[2] == $past(s.stk[3]) &&
    s.stk[3] == $past(s.stk[3]))
    else $error("pop wrong");

  literal_load_a: assert property (step && op == PFA_OP_RETLIT
    |=> wreg_load && wreg_value == $past(field[7:0]) ##1
    wreg_load == ($past(step) && $past(op) == PFA_OP_RETLIT))
    else $error("literal not loaded");

  bank_load_a: assert property (step && op == PFA_OP_BANK |=>
    s.bank == $past(field[2:0]))
    else $error("bank not loaded");

  direct_addr_a: assert property (acc_req && !ind_hit &&
    acc_file != `PFA_PCL_FILE && acc_file != `PFA_FSR_FILE |=>
    dmem_addr == {$past(s.bank), $past(acc_file)} &&
    (dmem_re || dmem_we))
    else $error("direct address wrong");

  ind_zero_a: assert property (acc_req && !acc_we && ind_hit &&
    s.file_pointer == `PFA_ZERO_BYTE |=> !dmem_re ##1
    acc_rvalid && acc_rdata == `PFA_ZERO_BYTE)
    else $error("self read not zero");

  ind_write_a: assert property (acc_req && acc_we && ind_hit &&
    s.file_pointer == `PFA_ZERO_BYTE |=> !dmem_we)
    else $error("self write stored");

  ind_addr_a: assert property (acc_req && ind_hit &&
    s.file_pointer != `PFA_ZERO_BYTE |=> dmem_addr == $past(s.file_pointer))
    else $error("indirect address wrong");

  // Alias, pointer, low byte, vector, wrap, page and bus timing checks
  pcl_alias_a: assert property (acc_req && !ind_hit &&
    acc_file == `PFA_PCL_FILE |=> s.rloc &&
    s.rlocval == $past(s.pc[7:0]) && !dmem_re && !dmem_we)
    else $error("low byte alias wrong");

  fsr_write_a: assert property (acc_req && acc_we && !ind_hit &&
    acc_file == `PFA_FSR_FILE |=> s.file_pointer == $past(acc_wdata))
    else $error("pointer not written");

  low_write_a: assert property (step && op == PFA_OP_PCLWR |=>
    s.pc == {$past(s.page[1:0]), 1'b0, $past(result)})
    else $error("low byte write wrong");

  irq_vector_a: assert property (step && op == PFA_OP_IRQ |=>
    s.pc == `PFA_IRQ_VEC)
    else $error("interrupt vector wrong");

  pc_wrap_a: assert property (step && op == PFA_OP_NONE &&
    s.pc == `PFA_PC_RST |=> s.pc == {`PFA_PC_W{1'b0}})
    else $error("counter did not wrap");

  page_load_a: assert property (step && op == PFA_OP_PAGE |=>
    s.page == $past(result[7:5]))
    else $error("page bits not loaded");

  apb_wait_a: assert property (psel && penable && !pready |=>
    pready)
    else $error("no answer after one wait state");

endmodule

/* pfa_dmem_model.sv */
// Data memory partner model for the addressing block
`timescale 1ns/100ps
module pfa_dmem_model (
  input  wire logic       pclk,       // Clock
  input  wire logic [7:0] dmem_addr,  // Address
  input  wire logic       dmem_re,    // Read strobe
  input  wire logic       dmem_we,    // Write strobe
  input  wire logic [7:0] dmem_wdata, // Write data
  output logic      [7:0] dmem_rdata  // Read data
);
  logic [7:0] mem [256];
  logic [7:0] last;
  // Known preset pattern so reads can be predicted
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    last = 8'h00;
  end
  // Store on write strobe, remember the last value shown
  always @(posedge pclk) begin
    if (dmem_we) mem[dmem_addr] <= dmem_wdata;
    if (dmem_re) last <= mem[dmem_addr];
  end
  // Data only while strobed, inverted junk otherwise
  assign dmem_rdata = dmem_re ? mem[dmem_addr] : ~last;
endmodule

/* pfa_core_tb_top.sv */
// Self-checking testbench for the program flow and addressing block
`timescale 1ns/100ps
`include "pfa_cfg.svh"
module pfa_core_tb_top
  import pfa_pkg::*;
;
  logic        pclk, presetn, step, acc_req, acc_we, psel, penable, pwrite;
  pfa_op_t     op;
  logic [8:0]  field;
  logic [7:0]  result, acc_wdata, dmem_rdata, wreg_value, dmem_addr;
  logic [7:0]  dmem_wdata, acc_rdata, v;
  logic [4:0]  acc_file;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] program_counter, epc;
  logic        wreg_load, dmem_re, dmem_we, acc_rvalid, pready, pslverr, err;
  logic [2:0]  epage, ebank;
  logic [11:0] estk [4];
  logic [7:0]  rq [$];
  logic [7:0]  wq [$];
  int          fail_count, samples_checked;
  integer      seed;
  pfa_op_t     rets [3] = '{PFA_OP_RETLIT, PFA_OP_RET, PFA_OP_RETINT};

  pfa_core dut (.pclk(pclk), .presetn(presetn), .step(step), .op(op),
    .field(field), .result(result), .acc_req(acc_req), .acc_we(acc_we),
    .acc_file(acc_file), .acc_wdata(acc_wdata), .dmem_rdata(dmem_rdata),
    .program_counter(program_counter), .wreg_load(wreg_load),
    .wreg_value(wreg_value), .dmem_addr(dmem_addr), .dmem_re(dmem_re),
    .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .acc_rvalid(acc_rvalid),
    .acc_rdata(acc_rdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  pfa_dmem_model mem (.pclk(pclk), .dmem_addr(dmem_addr),
    .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reference counter, page, bank and return stack
  task automatic model_op(input pfa_op_t o, input logic [8:0] f,
                          input logic [7:0] r);
    logic [10:0] nx;
    nx = epc + `PFA_PC_ONE;
    case (o)
      PFA_OP_JUMP: nx = {epage[1:0], f};
      PFA_OP_CALL, PFA_OP_IRQ: begin
        for (int k = 3; k > 0; k--)
          estk[k] = estk[k-1];
        estk[0] = {1'b0, nx};
        nx = (o == PFA_OP_IRQ) ? `PFA_IRQ_VEC : {epage[1:0], 1'b0, f[7:0]};
      end
      PFA_OP_RET, PFA_OP_RETLIT, PFA_OP_RETINT: begin
        nx = estk[0][10:0];
        for (int k = 0; k < 3; k++)
          estk[k] = estk[k+1];
        if (o == PFA_OP_RETLIT) wq.push_back(f[7:0]);
      end
      PFA_OP_PCLWR: nx = {epage[1:0], 1'b0, r};
      PFA_OP_BANK: ebank = f[2:0];
      PFA_OP_PAGE: epage = r[7:5];
      default: ;
    endcase
    epc = nx;
  endtask
  // One retired instruction, then counter check
  task automatic run_op(input pfa_op_t o, input logic [8:0] f,
                        input logic [7:0] r);
    @(posedge pclk);
    step <= 1'b1;
    op <= o;
    field <= f;
    result <= r;
    @(posedge pclk);
    step <= 1'b0;
    model_op(o, f, r);
    #1 cmp(program_counter, epc, "pc");
  endtask
  // One data access; strobe and address checked one cycle on
  task automatic acc(input logic we, input logic [4:0] fl,
                     input logic [7:0] wd, input logic [7:0] erd,
                     input logic [7:0] ead, input logic stb);
    @(posedge pclk);
    acc_req <= 1'b1;
    acc_we <= we;
    acc_file <= fl;
    acc_wdata <= wd;
    @(posedge pclk);
    acc_req <= 1'b0;
    if (!we) rq.push_back(erd);
    #1 cmp(dmem_re | dmem_we, stb, "strobe");
    if (stb) cmp(dmem_addr, ead, "address");
  endtask
  // APB transfer, held until pready seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp(n, 2, "apb wait");
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog, result monitor
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #300000;
    fail_count++;
    finish_test;
  end
  // Oldest expectation checked when a result appears
  always @(posedge pclk) begin
    if (wreg_load === 1'b1) begin
      if (wq.size() == 0) cmp(1, 0, "extra literal");
      else cmp(wreg_value, wq.pop_front(), "literal");
    end
    if (acc_rvalid === 1'b1) begin
      if (rq.size() == 0) cmp(1, 0, "extra read");
      else cmp(acc_rdata, rq.pop_front(), "read data");
    end
  end

  // Main sequence
  initial begin
    {step, acc_req, acc_we, psel, penable, pwrite, presetn} = '0;
    op = PFA_OP_NONE;
    {field, result, acc_wdata, acc_file, paddr, pwdata} = '0;
    seed = 32'ha50934d0;
    epc = `PFA_PC_RST;
    epage = `PFA_PAGE_RST;
    ebank = `PFA_BANK_RST;
    estk = '{default: `PFA_STK_RST};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cmp(program_counter, `PFA_PC_RST, "reset pc");
    apb(1'b0, `PFA_ADR_CTRL, 32'h0);
    cmp(rd, 32'h0, "ctrl reset");
    run_op(PFA_OP_NONE, 9'h000, 8'h00);
    run_op(PFA_OP_JUMP, 9'h1a5, 8'h00);
    run_op(PFA_OP_PAGE, 9'h000, 8'h60);
    run_op(PFA_OP_JUMP, 9'h0ab, 8'h00);
    run_op(PFA_OP_PCLWR, 9'h000, 8'h3c);
    acc(1'b0, `PFA_PCL_FILE, 8'h00, epc[7:0], 8'h00, 1'b0);
    for (int i = 0; i < 6; i++)
      run_op(i == 2 ? PFA_OP_IRQ : PFA_OP_CALL,
             9'($random(seed)), 8'h00);
    apb(1'b0, `PFA_ADR_TOP, 32'h0);
    cmp(rd, {20'h0, estk[0]}, "stack top");
    for (int i = 0; i < 6; i++)
      run_op(rets[i % 3], 9'($random(seed)), 8'h00);
    for (int i = 0; i < 5; i++) begin
      run_op(PFA_OP_BANK, 9'(i), 8'h00);
      v = {3'(i), 5'h05};
      acc(1'b0, 5'h05, 8'h00, v ^ 8'h5a, v, 1'b1);
    end
    apb(1'b0, `PFA_ADR_CTRL, 32'h0);
    cmp(rd, {25'h0, epage, 1'b0, ebank}, "ctrl");
    acc(1'b1, `PFA_FSR_FILE, 8'h13, 8'h00, 8'h00, 1'b0);
    v = 8'($random(seed));
    acc(1'b1, `PFA_IND_FILE, v, 8'h00, 8'h13, 1'b1);
    acc(1'b0, `PFA_IND_FILE, 8'h00, v, 8'h13, 1'b1);
    apb(1'b0, `PFA_ADR_FSR, 32'h0);
    cmp(rd, 32'h13, "pointer");
    apb(1'b1, `PFA_ADR_FSR, 32'h0);
    acc(1'b0, `PFA_IND_FILE, 8'h00, `PFA_ZERO_BYTE, 8'h00, 1'b0);
    acc(1'b1, `PFA_IND_FILE, 8'hff, 8'h00, 8'h00, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    cmp(err, 1'b1, "unmapped");
    // Second reset mid-run: counter to top, page cleared
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    epc = `PFA_PC_RST;
    epage = `PFA_PAGE_RST;
    ebank = `PFA_BANK_RST;
    estk = '{default: `PFA_STK_RST};
    cmp(program_counter, `PFA_PC_RST, "reset again");
    run_op(PFA_OP_JUMP, 9'h155, 8'h00);
    repeat (4) @(posedge pclk);
    cmp(rq.size() + wq.size(), 0, "pending");
    finish_test;
  end
endmodule
